// >>> inc/rwgc_pkg.sv
package rwgc_pkg;
    // register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN = 8'h14;
    // control bits
    localparam int CTRL_EN = 0;
    localparam int CTRL_CKDIS = 1;
    localparam int CTRL_SLPKEEP = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // live status bits
    localparam int ST_RDY = 0;
    localparam int ST_CLKERR = 1;
    localparam int ST_SEEDERR = 2;
    // event bits
    localparam int EV_SEED = 0;
    localparam int EV_CLK = 1;
    localparam int EV_W = 2;
    localparam logic [1:0] EV_RST = 2'h0;
    // data path and timing
    localparam int WORD_W = 32;
    localparam int NOISE_W = 4;
    localparam int FIFO_DEPTH = 4;
    localparam int MIX_ROT = 7;
    localparam logic [2:0] ROUND_WORDS = 3'h4;
    localparam logic [1:0] LOAD_LAST = 2'h3;
    localparam logic [7:0] ROUND_MIN_CYC = 8'hD5;
    localparam logic [4:0] BITS_LAST = 5'h1F;
    localparam logic [6:0] SAME_LIM = 7'h40;
    localparam logic [6:0] ALT_LIM = 7'h20;
    localparam logic [5:0] CLK_DIV = 6'h20;

    typedef struct packed {
        logic [7:0] addr;
        logic [WORD_W-1:0] wdata;
        logic wr;
        logic rd;
    } rwgc_bus_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'h0,
        PWR_SLEEP = 2'h1,
        PWR_STOP = 2'h2,
        PWR_OFF = 2'h3
    } rwgc_pwr_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_COLLECT = 2'h1,
        S_HOLD = 2'h3,
        S_LOAD = 2'h2
    } rwgc_state_t;
endpackage : rwgc_pkg

// >>> core/rwgc_fifo.sv
`timescale 1ns/1ps
module rwgc_fifo (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic push_in,
    input wire logic [rwgc_pkg::WORD_W-1:0] push_data_in,
    input wire logic pop_in,
    output logic [rwgc_pkg::WORD_W-1:0] head_out,
    output logic full_out,
    output logic empty_out
);
    logic [rwgc_pkg::WORD_W-1:0] mem_ff [rwgc_pkg::FIFO_DEPTH];
    logic [1:0] wr_ptr_ff;
    logic [1:0] rd_ptr_ff;
    logic [2:0] cnt_ff;
    logic do_push;
    logic do_pop;

    assign do_push = push_in && (cnt_ff != 3'(rwgc_pkg::FIFO_DEPTH));
    assign do_pop = pop_in && (cnt_ff != 3'h0);
    assign head_out = mem_ff[rd_ptr_ff];
    assign full_out = (cnt_ff == 3'(rwgc_pkg::FIFO_DEPTH));
    assign empty_out = (cnt_ff == 3'h0);

    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem_ff[wr_ptr_ff] <= push_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_ptr_ff <= 2'h0;
            rd_ptr_ff <= 2'h0;
            cnt_ff <= 3'h0;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= wr_ptr_ff + 2'h1;
            end
            if (do_pop) begin
                rd_ptr_ff <= rd_ptr_ff + 2'h1;
            end
            cnt_ff <= cnt_ff + 3'(do_push) - 3'(do_pop);
        end
    end
endmodule : rwgc_fifo

// >>> core/rwgc_seed_chk.sv
`timescale 1ns/1ps
module rwgc_seed_chk (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic clear_in,
    input wire logic bit_vld_in,
    input wire logic bit_in,
    output logic seed_err_out
);
    logic last_ff;
    logic have_ff;
    logic [6:0] same_cnt_ff;
    logic [6:0] alt_cnt_ff;

    // run length counters
    always_ff @(posedge clk_in) begin
        if (!resetn_in || clear_in) begin
            last_ff <= 1'h0;
            have_ff <= 1'h0;
            same_cnt_ff <= 7'h0;
            alt_cnt_ff <= 7'h0;
        end else if (bit_vld_in) begin
            last_ff <= bit_in;
            have_ff <= 1'h1;
            if (have_ff && (bit_in == last_ff)) begin
                same_cnt_ff <= (same_cnt_ff == 7'h7F) ? same_cnt_ff : same_cnt_ff + 7'h1;
                alt_cnt_ff <= 7'h1;
            end else begin
                same_cnt_ff <= 7'h1;
                alt_cnt_ff <= (alt_cnt_ff == 7'h7F) ? alt_cnt_ff : alt_cnt_ff + 7'h1;
            end
        end
    end

    // [RL4] [RL5] live pattern error
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            seed_err_out <= 1'h0;
        end else begin
            seed_err_out <= (same_cnt_ff > rwgc_pkg::SAME_LIM) || (alt_cnt_ff > rwgc_pkg::ALT_LIM);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_same_run;
        (same_cnt_ff > rwgc_pkg::SAME_LIM) |=> seed_err_out;
    endproperty
    a_same_run: assert property (p_same_run) else $error("long equal run not flagged"); // [RL4]

    property p_alt_run;
        (alt_cnt_ff <= rwgc_pkg::ALT_LIM) && (same_cnt_ff <= rwgc_pkg::SAME_LIM) |=> !seed_err_out;
    endproperty
    a_alt_run: assert property (p_alt_run) else $error("seed error without cause"); // [RL5]

    property p_alt_flag;
        (alt_cnt_ff > rwgc_pkg::ALT_LIM) |=> seed_err_out;
    endproperty
    a_alt_flag: assert property (p_alt_flag) else $error("long alternating run not flagged"); // [RL5]
endmodule : rwgc_seed_chk

// >>> core/rwgc_core.sv
`timescale 1ns/1ps
// Behaviour
// [RL1] four 32-bit words per round, min 213 cycles
// [RL2] ready flag only after validated words
// [RL3] reader checks ready flag before data
// [RL4] flag seed error on over 64 equal bits
// [RL5] flag seed error on over 32 alternations
// [RL6] flag clock error below bus clock/32
// [RL7] control bit disables clock check
// [RL8] software disables check for slow clock
// [RL9] enabled interrupt on seed or clock error
// [RL10] sample noise on generator clock, xor
// [RL11] words pass through four-word fifo
// [RL12] ready set when fifo full
// [RL13] ready cleared when fifo empty
// [RL14] runs in run, optionally sleep only
// [RL15] data read pops oldest word
// [RL16] live flags track conditions in parallel
module rwgc_core (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire rwgc_pkg::rwgc_bus_t bus_in,
    input wire logic gen_clk_in,
    input wire logic [rwgc_pkg::NOISE_W-1:0] noise_in,
    input wire rwgc_pkg::rwgc_pwr_t pwr_state_in,
    output logic [rwgc_pkg::WORD_W-1:0] rd_data_out,
    output logic irq_out,
    output logic gen_active_out
);
    localparam int ROUND_MIN_M1 = int'(rwgc_pkg::ROUND_MIN_CYC) - 1;

    function automatic logic [rwgc_pkg::WORD_W-1:0] mix(
        input logic [rwgc_pkg::WORD_W-1:0] a,
        input logic [rwgc_pkg::WORD_W-1:0] p
    );
        mix = a ^ ((p << rwgc_pkg::MIX_ROT) | (p >> (rwgc_pkg::WORD_W - rwgc_pkg::MIX_ROT)));
    endfunction : mix

    ////////////////////////////////////////////////////////////////
    // declarations
    logic gen_s1_ff;
    logic gen_s2_ff;
    logic gen_s3_ff;
    logic [rwgc_pkg::NOISE_W-1:0] noise_s1_ff;
    logic [rwgc_pkg::NOISE_W-1:0] noise_s2_ff;
    logic gen_edge;
    logic gen_on_ff;
    logic nxt_gen_on;
    logic [rwgc_pkg::CTRL_W-1:0] ctrl_ff;
    logic [5:0] clk_cnt_ff;
    logic clk_err_ff;
    logic seed_err;
    logic seed_err_d_ff;
    logic clk_err_d_ff;
    logic seed_vld;
    logic seed_bit;
    logic [rwgc_pkg::WORD_W-1:0] acc_ff;
    logic [4:0] bit_cnt_ff;
    logic [rwgc_pkg::WORD_W-1:0] prev_ff;
    logic word_vld;
    logic [rwgc_pkg::WORD_W-1:0] word_new;
    logic [rwgc_pkg::WORD_W-1:0] stage_ff [rwgc_pkg::FIFO_DEPTH];
    logic [2:0] word_idx_ff;
    logic [1:0] load_idx_ff;
    logic [7:0] round_cnt_ff;
    rwgc_pkg::rwgc_state_t state_ff;
    rwgc_pkg::rwgc_state_t nxt_state;
    logic fifo_push;
    logic fifo_pop;
    logic [rwgc_pkg::WORD_W-1:0] fifo_head;
    logic fifo_full;
    logic fifo_empty;
    logic rdy_ff;
    logic [rwgc_pkg::EV_W-1:0] irq_stat_ff;
    logic [rwgc_pkg::EV_W-1:0] irq_en_ff;
    logic [rwgc_pkg::EV_W-1:0] ev;
    logic [rwgc_pkg::EV_W-1:0] clr;
    logic wr_hit_clr;
    logic round_ok;

    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            gen_s1_ff <= 1'h0;
            gen_s2_ff <= 1'h0;
            gen_s3_ff <= 1'h0;
            noise_s1_ff <= '0;
            noise_s2_ff <= '0;
        end else begin
            gen_s1_ff <= gen_clk_in;
            gen_s2_ff <= gen_s1_ff;
            gen_s3_ff <= gen_s2_ff;
            noise_s1_ff <= noise_in;
            noise_s2_ff <= noise_s1_ff;
        end
    end

    assign gen_edge = gen_s2_ff && !gen_s3_ff;

    ////////////////////////////////////////////////////////////////
    // power gating
    always_comb begin
        nxt_gen_on = 1'h0;
        // [RL14] power state gating
        case (pwr_state_in)
            rwgc_pkg::PWR_RUN: nxt_gen_on = ctrl_ff[rwgc_pkg::CTRL_EN];
            rwgc_pkg::PWR_SLEEP: begin
                nxt_gen_on = ctrl_ff[rwgc_pkg::CTRL_EN] && ctrl_ff[rwgc_pkg::CTRL_SLPKEEP];
            end
            default: nxt_gen_on = 1'h0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            gen_on_ff <= 1'h0;
        end else begin
            gen_on_ff <= nxt_gen_on;
        end
    end

    ////////////////////////////////////////////////////////////////
    // clock frequency check
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            clk_cnt_ff <= 6'h0;
        end else if (!gen_on_ff || gen_edge) begin
            clk_cnt_ff <= 6'h0;
        end else if (clk_cnt_ff != rwgc_pkg::CLK_DIV) begin
            clk_cnt_ff <= clk_cnt_ff + 6'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            clk_err_ff <= 1'h0;
        end else begin
            // [RL6] [RL7] [RL16] live clock error
            clk_err_ff <= gen_on_ff && !ctrl_ff[rwgc_pkg::CTRL_CKDIS] && (clk_cnt_ff == rwgc_pkg::CLK_DIV);
        end
    end

    ////////////////////////////////////////////////////////////////
    // seed sampling and checking
    // [RL10] xor of sampled oscillators
    assign seed_vld = gen_on_ff && gen_edge;
    assign seed_bit = ^noise_s2_ff;

    // [RL16] seed check beside generation
    rwgc_seed_chk u_seed_chk (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .clear_in(!gen_on_ff),
        .bit_vld_in(seed_vld),
        .bit_in(seed_bit),
        .seed_err_out(seed_err)
    );

    ////////////////////////////////////////////////////////////////
    // post processing
    assign word_vld = seed_vld && (bit_cnt_ff == rwgc_pkg::BITS_LAST);
    assign word_new = mix({acc_ff[rwgc_pkg::WORD_W-2:0], seed_bit}, prev_ff);

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            acc_ff <= '0;
            bit_cnt_ff <= 5'h0;
            prev_ff <= '0;
        end else if (!gen_on_ff) begin
            bit_cnt_ff <= 5'h0;
        end else if (seed_vld) begin
            acc_ff <= {acc_ff[rwgc_pkg::WORD_W-2:0], seed_bit};
            bit_cnt_ff <= bit_cnt_ff + 5'h1;
            if (word_vld) begin
                prev_ff <= word_new;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // round sequencer
    assign round_ok = (round_cnt_ff >= (rwgc_pkg::ROUND_MIN_CYC - 8'h1)) && fifo_empty && !seed_err;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            rwgc_pkg::S_IDLE: begin
                if (gen_on_ff) begin
                    nxt_state = rwgc_pkg::S_COLLECT;
                end
            end
            rwgc_pkg::S_COLLECT: begin
                if (word_idx_ff == rwgc_pkg::ROUND_WORDS) begin
                    nxt_state = rwgc_pkg::S_HOLD;
                end
            end
            rwgc_pkg::S_HOLD: begin
                // [RL1] [RL2] minimum round, validated words
                if (seed_err) begin
                    nxt_state = rwgc_pkg::S_COLLECT;
                end else if (round_ok) begin
                    nxt_state = rwgc_pkg::S_LOAD;
                end
            end
            rwgc_pkg::S_LOAD: begin
                if (load_idx_ff == rwgc_pkg::LOAD_LAST) begin
                    nxt_state = rwgc_pkg::S_COLLECT;
                end
            end
            default: nxt_state = rwgc_pkg::S_IDLE;
        endcase
        if (!gen_on_ff) begin
            nxt_state = rwgc_pkg::S_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_ff <= rwgc_pkg::S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            round_cnt_ff <= 8'h0;
        end else if (nxt_state == rwgc_pkg::S_COLLECT && state_ff != rwgc_pkg::S_COLLECT) begin
            round_cnt_ff <= 8'h0;
        end else if (round_cnt_ff != 8'hFF) begin
            round_cnt_ff <= round_cnt_ff + 8'h1;
        end
    end

    // [RL1] four words per round
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            word_idx_ff <= 3'h0;
        end else if (state_ff != rwgc_pkg::S_COLLECT || seed_err) begin
            word_idx_ff <= 3'h0;
        end else if (word_vld && word_idx_ff != rwgc_pkg::ROUND_WORDS) begin
            word_idx_ff <= word_idx_ff + 3'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (state_ff == rwgc_pkg::S_COLLECT && word_vld && word_idx_ff != rwgc_pkg::ROUND_WORDS) begin
            stage_ff[word_idx_ff[1:0]] <= word_new;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            load_idx_ff <= 2'h0;
        end else if (state_ff == rwgc_pkg::S_LOAD) begin
            load_idx_ff <= load_idx_ff + 2'h1;
        end else begin
            load_idx_ff <= 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // output fifo
    // [RL11] words pass fifo
    assign fifo_push = (state_ff == rwgc_pkg::S_LOAD);
    // [RL15] read pops head
    assign fifo_pop = bus_in.rd && (bus_in.addr == rwgc_pkg::OFF_DATA) && !fifo_empty;

    rwgc_fifo u_fifo (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .push_in(fifo_push),
        .push_data_in(stage_ff[load_idx_ff]),
        .pop_in(fifo_pop),
        .head_out(fifo_head),
        .full_out(fifo_full),
        .empty_out(fifo_empty)
    );

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rdy_ff <= 1'h0;
        end else if (fifo_full) begin
            // [RL12] ready on full
            rdy_ff <= 1'h1;
        end else if (fifo_empty) begin
            // [RL13] clear on empty
            rdy_ff <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // registers and interrupt
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ctrl_ff <= rwgc_pkg::CTRL_RST;
            irq_en_ff <= rwgc_pkg::EV_RST;
        end else if (bus_in.wr) begin
            if (bus_in.addr == rwgc_pkg::OFF_CTRL) begin
                ctrl_ff <= bus_in.wdata[rwgc_pkg::CTRL_W-1:0];
            end
            if (bus_in.addr == rwgc_pkg::OFF_IRQ_EN) begin
                irq_en_ff <= bus_in.wdata[rwgc_pkg::EV_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            seed_err_d_ff <= 1'h0;
            clk_err_d_ff <= 1'h0;
        end else begin
            seed_err_d_ff <= seed_err;
            clk_err_d_ff <= clk_err_ff;
        end
    end

    assign ev = {clk_err_ff && !clk_err_d_ff, seed_err && !seed_err_d_ff};
    assign wr_hit_clr = bus_in.wr && (bus_in.addr == rwgc_pkg::OFF_IRQ_CLR);
    assign clr = wr_hit_clr ? bus_in.wdata[rwgc_pkg::EV_W-1:0] : rwgc_pkg::EV_RST;

    // [RL9] sticky events, set wins
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_stat_ff <= rwgc_pkg::EV_RST;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_out <= 1'h0;
        end else begin
            irq_out <= |(irq_stat_ff & irq_en_ff);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            gen_active_out <= 1'h0;
        end else begin
            gen_active_out <= gen_on_ff;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rd_data_out <= '0;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                rwgc_pkg::OFF_CTRL: rd_data_out <= rwgc_pkg::WORD_W'(ctrl_ff);
                rwgc_pkg::OFF_STATUS: begin
                    rd_data_out <= rwgc_pkg::WORD_W'({seed_err, clk_err_ff, rdy_ff});
                end
                rwgc_pkg::OFF_DATA: rd_data_out <= fifo_empty ? '0 : fifo_head;
                rwgc_pkg::OFF_IRQ_STAT: rd_data_out <= rwgc_pkg::WORD_W'(irq_stat_ff);
                rwgc_pkg::OFF_IRQ_EN: rd_data_out <= rwgc_pkg::WORD_W'(irq_en_ff);
                default: rd_data_out <= '0;
            endcase
        end else begin
            rd_data_out <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_load_enter;
        (state_ff == rwgc_pkg::S_HOLD) ##1 (state_ff == rwgc_pkg::S_LOAD);
    endsequence

    sequence s_load_burst;
        (fifo_push && state_ff == rwgc_pkg::S_LOAD) [*4] ##1 (state_ff != rwgc_pkg::S_LOAD);
    endsequence

    property p_round_min;
        disable iff (!resetn_in || !gen_on_ff)
        s_load_enter |-> ($past(round_cnt_ff) >= ROUND_MIN_M1) ##0 s_load_burst;
    endproperty
    a_round_min: assert property (p_round_min) else $error("round too short or burst wrong"); // [RL1]

    property p_rdy_valid;
        $rose(rdy_ff) |-> $past(fifo_full);
    endproperty
    a_rdy_valid: assert property (p_rdy_valid) else $error("ready without full fifo"); // [RL2]

    property p_rdy_full;
        fifo_full |=> rdy_ff;
    endproperty
    a_rdy_full: assert property (p_rdy_full) else $error("ready missing on full"); // [RL12]

    property p_rdy_empty;
        fifo_empty |=> !rdy_ff;
    endproperty
    a_rdy_empty: assert property (p_rdy_empty) else $error("ready stuck when empty"); // [RL13]

    property p_clk_err;
        gen_on_ff && !ctrl_ff[rwgc_pkg::CTRL_CKDIS] && clk_cnt_ff == rwgc_pkg::CLK_DIV |=> clk_err_ff;
    endproperty
    a_clk_err: assert property (p_clk_err) else $error("slow clock not flagged"); // [RL6]

    property p_clk_dis;
        ctrl_ff[rwgc_pkg::CTRL_CKDIS] |=> !clk_err_ff;
    endproperty
    a_clk_dis: assert property (p_clk_dis) else $error("clock error while check off"); // [RL7]

    property p_irq;
        (|(irq_stat_ff & irq_en_ff)) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised"); // [RL9]

    property p_irq_low;
        !(|(irq_stat_ff & irq_en_ff)) |=> !irq_out;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt without enabled event"); // [RL9]

    property p_ev_set;
        (|ev) |=> ((irq_stat_ff & $past(ev)) == $past(ev));
    endproperty
    a_ev_set: assert property (p_ev_set) else $error("event lost against clear"); // [RL9]

    property p_pwr;
        (pwr_state_in == rwgc_pkg::PWR_STOP || pwr_state_in == rwgc_pkg::PWR_OFF) |=> !gen_on_ff ##1 !gen_active_out;
    endproperty
    a_pwr: assert property (p_pwr) else $error("generator on in deep state"); // [RL14]

    property p_pop;
        fifo_pop |=> (rd_data_out == $past(fifo_head));
    endproperty
    a_pop: assert property (p_pop) else $error("data read not oldest word"); // [RL15]
endmodule : rwgc_core

// >>> dv/rwgc_noise_model.sv
`timescale 1ns/1ps
module rwgc_noise_model (
    input wire logic [1:0] mode_in,
    output logic gen_clk_out,
    output logic [3:0] noise_out
);
    logic [15:0] lfsr;
    logic alt;
    ////////////////////////////////////////////////////////////////
    // free running 20 ns generator clock, held still in mode 3
    initial begin
        gen_clk_out = 1'h0;
        noise_out = 4'h0;
        lfsr = 16'hACE1;
        alt = 1'h0;
        forever begin
            #10;
            if (mode_in != 2'h3) begin
                gen_clk_out = ~gen_clk_out;
            end
            if (!gen_clk_out) begin
                lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
                alt = ~alt;
                case (mode_in)
                    2'h1: noise_out = 4'h1;
                    2'h2: noise_out = {3'h0, alt};
                    default: noise_out = lfsr[3:0];
                endcase
            end
        end
    end
endmodule : rwgc_noise_model

// >>> dv/rwgc_core_bench.sv
`timescale 1ns/1ps
module rwgc_core_bench;
    logic clk;
    logic resetn;
    rwgc_pkg::rwgc_bus_t bus;
    rwgc_pkg::rwgc_pwr_t pwr;
    logic [1:0] mode;
    logic gen_clk;
    logic [3:0] noise;
    logic [31:0] rdata;
    logic irq;
    logic active;
    logic [31:0] rv;
    logic [31:0] w [4];
    int n_mismatch = 0;
    int checked = 0;
    int n;

    rwgc_core rwgc_core_inst (.clk_in(clk), .resetn_in(resetn), .bus_in(bus), .gen_clk_in(gen_clk),
        .noise_in(noise), .pwr_state_in(pwr), .rd_data_out(rdata), .irq_out(irq), .gen_active_out(active));
    rwgc_noise_model rwgc_noise_model_inst (.mode_in(mode), .gen_clk_out(gen_clk), .noise_out(noise));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task bus_op(input logic [7:0] addr, input logic [31:0] wdata, input logic wr);
        @(posedge clk);
        bus <= '{addr: addr, wdata: wdata, wr: wr, rd: ~wr};
        @(posedge clk);
        bus <= '0;
        #1;
        rv = rdata;
    endtask : bus_op

    task poll(input int b, input int lim);
        n = 0;
        do begin
            bus_op(rwgc_pkg::OFF_STATUS, 32'h0, 1'h0);
            n++;
        end while (rv[b] !== 1'h1 && n < lim);
    endtask : poll

    task wait_clk(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : wait_clk

    task end_of_test;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////
    task t_reset;
        check({31'h0, irq}, 32'h0);
        check({31'h0, active}, 32'h0);
        bus_op(rwgc_pkg::OFF_STATUS, 32'h0, 1'h0);
        check(rv, 32'h0);
        bus_op(rwgc_pkg::OFF_DATA, 32'h0, 1'h0);
        check(rv, 32'h0);
        bus_op(8'h20, 32'h0, 1'h0);
        check(rv, 32'h0);
        bus_op(rwgc_pkg::OFF_IRQ_EN, 32'h3, 1'h1);
        bus_op(rwgc_pkg::OFF_IRQ_EN, 32'h0, 1'h0);
        check(rv, 32'h3);
        bus_op(rwgc_pkg::OFF_IRQ_EN, 32'h0, 1'h1);
    endtask : t_reset

    task t_round;
        bus_op(rwgc_pkg::OFF_CTRL, 32'h1, 1'h1);
        wait_clk(3);
        check({31'h0, active}, 32'h1);
        poll(rwgc_pkg::ST_RDY, 2000);
        check({31'h0, rv[rwgc_pkg::ST_RDY]}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            bus_op(rwgc_pkg::OFF_DATA, 32'h0, 1'h0);
            w[i] = rv;
            if (i == 2) begin
                bus_op(rwgc_pkg::OFF_STATUS, 32'h0, 1'h0);
                check({31'h0, rv[rwgc_pkg::ST_RDY]}, 32'h1);
            end
        end
        check({31'h0, w[0] !== w[1] && w[1] !== w[2] && w[2] !== w[3]}, 32'h1);
        wait_clk(2);
        bus_op(rwgc_pkg::OFF_STATUS, 32'h0, 1'h0);
        check({31'h0, rv[rwgc_pkg::ST_RDY]}, 32'h0);
        bus_op(rwgc_pkg::OFF_DATA, 32'h0, 1'h0);
        check(rv, 32'h0);
        poll(rwgc_pkg::ST_RDY, 2000);
        check({31'h0, rv[rwgc_pkg::ST_RDY]}, 32'h1);
        check({31'h0, n * 2 >= 213}, 32'h1);
    endtask : t_round

    task t_seed(input logic [1:0] m, input int bits);
        @(posedge clk);
        mode <= m;
        wait_clk(bits * 4 + 20);
        bus_op(rwgc_pkg::OFF_STATUS, 32'h0, 1'h0);
        check({31'h0, rv[rwgc_pkg::ST_SEEDERR]}, 32'h1);
        bus_op(rwgc_pkg::OFF_IRQ_STAT, 32'h0, 1'h0);
        check({31'h0, rv[rwgc_pkg::EV_SEED]}, 32'h1);
        check({31'h0, irq}, 32'h0);
        bus_op(rwgc_pkg::OFF_IRQ_EN, 32'h1, 1'h1);
        wait_clk(2);
        check({31'h0, irq}, 32'h1);
        @(posedge clk);
        mode <= 2'h0;
        wait_clk(200);
        bus_op(rwgc_pkg::OFF_STATUS, 32'h0, 1'h0);
        check({31'h0, rv[rwgc_pkg::ST_SEEDERR]}, 32'h0);
        bus_op(rwgc_pkg::OFF_IRQ_CLR, 32'h3, 1'h1);
        bus_op(rwgc_pkg::OFF_IRQ_STAT, 32'h0, 1'h0);
        check(rv, 32'h0);
        wait_clk(2);
        check({31'h0, irq}, 32'h0);
        bus_op(rwgc_pkg::OFF_IRQ_EN, 32'h0, 1'h1);
    endtask : t_seed

    task t_clk;
        @(posedge clk);
        mode <= 2'h3;
        wait_clk(16);
        bus_op(rwgc_pkg::OFF_STATUS, 32'h0, 1'h0);
        check({31'h0, rv[rwgc_pkg::ST_CLKERR]}, 32'h0);
        wait_clk(40);
        bus_op(rwgc_pkg::OFF_STATUS, 32'h0, 1'h0);
        check({31'h0, rv[rwgc_pkg::ST_CLKERR]}, 32'h1);
        bus_op(rwgc_pkg::OFF_IRQ_STAT, 32'h0, 1'h0);
        check({31'h0, rv[rwgc_pkg::EV_CLK]}, 32'h1);
        bus_op(rwgc_pkg::OFF_CTRL, 32'h3, 1'h1);
        wait_clk(4);
        bus_op(rwgc_pkg::OFF_STATUS, 32'h0, 1'h0);
        check({31'h0, rv[rwgc_pkg::ST_CLKERR]}, 32'h0);
        bus_op(rwgc_pkg::OFF_CTRL, 32'h0, 1'h0);
        check(rv, 32'h3);
        @(posedge clk);
        mode <= 2'h0;
        wait_clk(8);
        bus_op(rwgc_pkg::OFF_CTRL, 32'h1, 1'h1);
        bus_op(rwgc_pkg::OFF_IRQ_CLR, 32'h3, 1'h1);
    endtask : t_clk

    task t_pwr;
        static logic [1:0] ps [5] = '{2'h2, 2'h1, 2'h1, 2'h3, 2'h0};
        static logic [2:0] cs [5] = '{3'h1, 3'h1, 3'h5, 3'h5, 3'h1};
        static logic ea [5] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1};
        for (int i = 0; i < 5; i++) begin
            bus_op(rwgc_pkg::OFF_CTRL, {29'h0, cs[i]}, 1'h1);
            @(posedge clk);
            pwr <= rwgc_pkg::rwgc_pwr_t'(ps[i]);
            wait_clk(4);
            check({31'h0, active}, {31'h0, ea[i]});
        end
    endtask : t_pwr
    ////////////////////////////////////////////////////////////////
    initial begin
        bus = '0;
        pwr = rwgc_pkg::PWR_RUN;
        mode = 2'h0;
        resetn = 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        wait_clk(1);
        t_reset();
        t_round();
        t_seed(2'h1, 80);
        t_seed(2'h2, 40);
        t_clk();
        t_pwr();
        end_of_test();
    end

    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule : rwgc_core_bench
